//--- rtl/fsp_pkg.sv
package fsp_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [9:0] ADDR_CONTROL = 10'h01f;
    localparam logic [9:0] ADDR_SKEW = 10'h055;
    localparam logic [9:0] ADDR_SYNC = 10'h0e9;
    localparam logic [9:0] ADDR_RX_FEATURE = 10'h134;
    localparam logic [9:0] ADDR_SEL_A = 10'h171;
    localparam logic [9:0] ADDR_SEL_B = 10'h172;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int SOFT_RELINK_BIT = 14;
    localparam int PULSE_ALLOW_BIT = 7;
    localparam int MASTER_SKEW_LSB = 4;
    localparam int SLAVE_SKEW_LSB = 0;
    localparam int TX_PHASE_LSB = 0;
    localparam int RX_PHASE_LSB = 4;
    localparam int FIELD_W = 4;

    // ----------------------------------------
    // Reset and key values
    // ----------------------------------------
    localparam logic [15:0] RST_CONTROL = 16'h0000;
    localparam logic [15:0] RST_SYNC = 16'h0000;
    localparam logic [15:0] RST_RX_FEATURE = 16'h0000;
    localparam logic [15:0] RST_SEL_A = 16'h0000;
    localparam logic [15:0] RST_SEL_B = 16'h0000;
    localparam logic [15:0] SYNC_INIT = 16'hdf22;
    localparam logic [3:0] SKEW_LIMIT = 4'h1;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int PHASE_STEP_NS = 8;
    localparam int CLK_PERIOD_NS = 25;
    localparam int STEP_CYC_RAW = (PHASE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STEP_CYC = (STEP_CYC_RAW < 1) ? 1 : STEP_CYC_RAW;

    // ----------------------------------------
    // Enumerations
    // ----------------------------------------
    typedef enum logic [3:0] {
        SRC_NONE = 4'h0,
        SRC_TX = 4'h1,
        SRC_RX = 4'h2
    } fsp_src_e;

    typedef enum logic [1:0] {
        LNK_DOWN = 2'b00,
        LNK_UP = 2'b01,
        LNK_WAIT = 2'b10
    } fsp_link_e;

endpackage : fsp_pkg

//--- rtl/fsp_pulse_delay.sv
`timescale 1ns/100ps

module fsp_pulse_delay #(
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // Pulse path
    input wire logic pulse_i,
    input wire logic [$clog2(DEPTH)-1:0] delay_i,
    output logic pulse_o
);

    generate
        if (DEPTH < 2) begin : g_bad_depth
            $error("fsp_pulse_delay needs DEPTH of at least 2.");
        end
    endgenerate

    typedef struct packed {
        logic [DEPTH-1:0] line;
        logic out;
    } fsp_dly_s;

    fsp_dly_s state;
    fsp_dly_s next_state;
    logic [DEPTH:0] taps;

    // ----------------------------------------
    // Delay line
    // ----------------------------------------
    always_comb begin
        taps = {state.line, pulse_i};
        next_state.line = {state.line[DEPTH-2:0], pulse_i};
        next_state.out = taps[delay_i];
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign pulse_o = state.out;

endmodule : fsp_pulse_delay

//--- rtl/fsp_frame_start.sv
`timescale 1ns/100ps

module fsp_frame_start #(
    parameter int NPIN = 4,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // Management register port
    input wire logic [9:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Line events
    input wire logic tx_frame_start_i,
    input wire logic rx_frame_start_i,
    input wire logic link_up_i,
    input wire logic gig_mode_i,
    input wire logic master_mode_i,
    input wire logic [3:0] align_skew_i,
    // Pins and link control
    output logic [NPIN-1:0] pin_o,
    output logic soft_relink_o
);

    localparam int DW = $clog2(DEPTH);

    generate
        if (NPIN < 1 || NPIN > 4) begin : g_bad_npin
            $error("fsp_frame_start supports 1 to 4 pins.");
        end
        if (DEPTH < 32) begin : g_bad_depth
            $error("fsp_frame_start needs DEPTH of at least 32.");
        end
    endgenerate

    typedef struct packed {
        logic [15:0] control;
        logic [15:0] sync_setup;
        logic [15:0] rx_feature;
        logic [15:0] sel_a;
        logic [15:0] sel_b;
        logic [7:0] skew_stat;
        logic [3:0] skew_apply;
        fsp_pkg::fsp_link_e link;
        logic tx_prev;
        logic rx_prev;
        logic relink;
        logic [NPIN-1:0] pins;
        logic [15:0] rdata;
        logic rvalid;
    } fsp_state_s;

    fsp_state_s state;
    fsp_state_s next_state;
    logic tx_edge;
    logic rx_edge;
    logic tx_dly;
    logic rx_dly;
    logic [DW-1:0] tx_delay;
    logic [DW-1:0] rx_delay;
    logic [NPIN-1:0] pin_next;
    logic [3:0] skew_lim;

    // ----------------------------------------
    // Frame edge detection
    // ----------------------------------------
    assign tx_edge = tx_frame_start_i && !state.tx_prev;
    assign rx_edge = rx_frame_start_i && !state.rx_prev;

    // ----------------------------------------
    // Latency programming
    // ----------------------------------------
    assign tx_delay = DW'(32'(state.sel_b[fsp_pkg::TX_PHASE_LSB +: fsp_pkg::FIELD_W])
        * fsp_pkg::STEP_CYC);
    assign rx_delay = DW'((32'(state.sel_b[fsp_pkg::RX_PHASE_LSB +: fsp_pkg::FIELD_W])
        + 32'(state.skew_apply)) * fsp_pkg::STEP_CYC);

    fsp_pulse_delay #(
        .DEPTH(DEPTH)
    ) u_tx_delay (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .pulse_i(tx_edge),
        .delay_i(tx_delay),
        .pulse_o(tx_dly)
    );

    fsp_pulse_delay #(
        .DEPTH(DEPTH)
    ) u_rx_delay (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .pulse_i(rx_edge),
        .delay_i(rx_delay),
        .pulse_o(rx_dly)
    );

    // ----------------------------------------
    // Pin routing
    // ----------------------------------------
    generate
        for (genvar g = 0; g < NPIN; g++) begin : g_pin
            logic [3:0] sel;
            assign sel = state.sel_a[g*fsp_pkg::FIELD_W +: fsp_pkg::FIELD_W];
            assign pin_next[g] = state.rx_feature[fsp_pkg::PULSE_ALLOW_BIT]
                && ((sel == fsp_pkg::SRC_TX && tx_dly)
                || (sel == fsp_pkg::SRC_RX && rx_dly));
        end
    endgenerate

    assign skew_lim = (align_skew_i > fsp_pkg::SKEW_LIMIT) ? fsp_pkg::SKEW_LIMIT : align_skew_i;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_state = state;
        next_state.tx_prev = tx_frame_start_i;
        next_state.rx_prev = rx_frame_start_i;
        next_state.relink = 1'b0;
        next_state.pins = pin_next;
        next_state.rvalid = reg_rd_i;
        if (reg_wr_i) begin
            case (reg_addr_i)
                fsp_pkg::ADDR_CONTROL: begin
                    next_state.control = reg_wdata_i;
                    next_state.control[fsp_pkg::SOFT_RELINK_BIT] = 1'b0;
                    next_state.relink = reg_wdata_i[fsp_pkg::SOFT_RELINK_BIT];
                end
                fsp_pkg::ADDR_SYNC: next_state.sync_setup = reg_wdata_i;
                fsp_pkg::ADDR_RX_FEATURE: next_state.rx_feature = reg_wdata_i;
                fsp_pkg::ADDR_SEL_A: next_state.sel_a = reg_wdata_i;
                fsp_pkg::ADDR_SEL_B: next_state.sel_b = reg_wdata_i;
                default: next_state.control = state.control;
            endcase
        end
        case (state.link)
            fsp_pkg::LNK_DOWN: begin
                if (link_up_i) begin
                    next_state.link = fsp_pkg::LNK_UP;
                    next_state.skew_stat = 8'h00;
                    next_state.skew_apply = 4'h0;
                    if (gig_mode_i) begin
                        if (state.sync_setup == fsp_pkg::SYNC_INIT) begin
                            next_state.skew_apply = skew_lim;
                            if (master_mode_i) begin
                                next_state.skew_stat[fsp_pkg::MASTER_SKEW_LSB +: 4] =
                                    skew_lim;
                            end else begin
                                next_state.skew_stat[fsp_pkg::SLAVE_SKEW_LSB +: 4] =
                                    skew_lim;
                            end
                        end else begin
                            next_state.skew_apply = align_skew_i;
                        end
                    end
                end
            end
            fsp_pkg::LNK_UP: begin
                if (!link_up_i) begin
                    next_state.link = fsp_pkg::LNK_DOWN;
                end
            end
            fsp_pkg::LNK_WAIT: begin
                if (!link_up_i) begin
                    next_state.link = fsp_pkg::LNK_DOWN;
                end
            end
            default: next_state.link = fsp_pkg::LNK_DOWN;
        endcase
        if (state.relink) begin
            next_state.link = fsp_pkg::LNK_WAIT;
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                fsp_pkg::ADDR_CONTROL: next_state.rdata = state.control;
                fsp_pkg::ADDR_SKEW: next_state.rdata = {8'h00, state.skew_stat};
                fsp_pkg::ADDR_SYNC: next_state.rdata = state.sync_setup;
                fsp_pkg::ADDR_RX_FEATURE: next_state.rdata = state.rx_feature;
                fsp_pkg::ADDR_SEL_A: next_state.rdata = state.sel_a;
                fsp_pkg::ADDR_SEL_B: next_state.rdata = state.sel_b;
                default: next_state.rdata = 16'h0000;
            endcase
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= '0;
            state.control <= fsp_pkg::RST_CONTROL;
            state.sync_setup <= fsp_pkg::RST_SYNC;
            state.rx_feature <= fsp_pkg::RST_RX_FEATURE;
            state.sel_a <= fsp_pkg::RST_SEL_A;
            state.sel_b <= fsp_pkg::RST_SEL_B;
            state.link <= fsp_pkg::LNK_DOWN;
        end else begin
            state <= next_state;
        end
    end

    assign pin_o = state.pins;
    assign soft_relink_o = state.relink;
    assign reg_rdata_o = state.rdata;
    assign reg_rvalid_o = state.rvalid;

endmodule : fsp_frame_start

//--- testbench/fsp_frame_start_props.sv
`timescale 1ns/100ps

// ----------------------------------------
// Port checker
// ----------------------------------------
module fsp_frame_start_props #(
    parameter int NPIN = 4
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // Register port
    input wire logic [9:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    // Line events and pins
    input wire logic tx_frame_start_i,
    input wire logic rx_frame_start_i,
    input wire logic [NPIN-1:0] pin_o,
    input wire logic soft_relink_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    logic allow;
    logic [5:0] idle;

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            allow <= 1'b0;
            idle <= 6'h00;
        end else begin
            if (reg_wr_i && reg_addr_i == fsp_pkg::ADDR_RX_FEATURE) begin
                allow <= reg_wdata_i[fsp_pkg::PULSE_ALLOW_BIT];
            end
            if (allow && (tx_frame_start_i || rx_frame_start_i)) begin
                idle <= 6'h00;
            end else if (idle != 6'h3f) begin
                idle <= idle + 6'h01;
            end
        end
    end

    a_read_answered: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read not answered");
    a_answer_has_read: assert property (reg_rvalid_o |-> $past(reg_rd_i))
        else $error("answer without read");
    a_restart_reads_zero: assert property (reg_rd_i
        && reg_addr_i == fsp_pkg::ADDR_CONTROL
        |=> !reg_rdata_o[fsp_pkg::SOFT_RELINK_BIT]) else $error("restart bit reads one");
    a_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 10'h3ff
        |=> reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
    a_sync_write_back: assert property (reg_wr_i && reg_addr_i == fsp_pkg::ADDR_SYNC
        ##1 !reg_wr_i ##1 reg_rd_i && reg_addr_i == fsp_pkg::ADDR_SYNC
        |=> reg_rdata_o == $past(reg_wdata_i, 3)) else $error("sync setup lost");
    a_relink_issued: assert property (reg_wr_i && reg_addr_i == fsp_pkg::ADDR_CONTROL
        && reg_wdata_i[14] |=> soft_relink_o) else $error("relink missing");
    a_relink_cause: assert property (soft_relink_o
        |-> $past(reg_wr_i) && $past(reg_wdata_i[fsp_pkg::SOFT_RELINK_BIT]))
        else $error("relink without write");
    a_pin_one_cycle: assert property ((pin_o & $past(pin_o)) == '0)
        else $error("pin pulse too long");
    a_pin_quiet: assert property (idle > 6'h28 |-> pin_o == '0)
        else $error("pin pulse without cause");

    c_tx_pin: cover property (tx_frame_start_i ##2 pin_o[0]);
    c_rx_pin: cover property (rx_frame_start_i ##[2:40] pin_o != '0);
    c_relink: cover property (soft_relink_o);
endmodule : fsp_frame_start_props

bind fsp_frame_start fsp_frame_start_props #(.NPIN(NPIN)) i_props (.ref_clk_i, .rst_b_i,
    .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o,
    .tx_frame_start_i, .rx_frame_start_i, .pin_o, .soft_relink_o);

//--- testbench/fsp_stamp_capture.sv
`timescale 1ns/100ps

module fsp_stamp_capture #(
    parameter int NPIN = 4
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // Pins and captures
    input wire logic [NPIN-1:0] pin_i,
    output logic [31:0] now_o,
    output logic [31:0] stamp_o [NPIN],
    output logic [7:0] count_o [NPIN]
);
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            now_o <= '0;
            stamp_o <= '{default: '0};
            count_o <= '{default: '0};
        end else begin
            now_o <= now_o + 32'h0000_0001;
            for (int g = 0; g < NPIN; g++) begin
                if (pin_i[g]) begin
                    stamp_o[g] <= now_o;
                    count_o[g] <= count_o[g] + 8'h01;
                end
            end
        end
    end
endmodule : fsp_stamp_capture

//--- testbench/tb_top.sv
`timescale 1ns/100ps

module tb_top;
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [9:0] addr = '0;
    logic [15:0] wdata = '0;
    logic wr = 1'b0, rd = 1'b0, tx = 1'b0, rx = 1'b0, lnk = 1'b0, gig = 1'b0, mst = 1'b0;
    logic [3:0] skew = '0;
    logic [15:0] rdata;
    logic rvalid, relink;
    logic [3:0] pins;
    logic [31:0] now;
    logic [31:0] stamp [4];
    logic [7:0] count [4];
    int n_fail = 0;
    int checked = 0;

    fsp_frame_start i_dut (.ref_clk_i, .rst_b_i, .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .tx_frame_start_i(tx), .rx_frame_start_i(rx), .link_up_i(lnk), .gig_mode_i(gig),
        .master_mode_i(mst),
        .align_skew_i(skew), .pin_o(pins), .soft_relink_o(relink));
    fsp_stamp_capture i_cap (.ref_clk_i, .rst_b_i, .pin_i(pins), .now_o(now), .stamp_o(stamp),
        .count_o(count));

    initial begin
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr_reg(input logic [9:0] a, input logic [15:0] d);
        @(negedge ref_clk_i);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge ref_clk_i);
        wr = 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [9:0] a, input logic [15:0] exp);
        @(negedge ref_clk_i);
        addr = a;
        rd = 1'b1;
        @(negedge ref_clk_i);
        rd = 1'b0;
        chk("rvalid", 1, rvalid);
        chk("rdata", exp, rdata);
    endtask : rd_reg

    task automatic send(input bit is_rx, input int hold, input int g, input int lat, input int n);
        logic [31:0] t0;
        logic [7:0] c0;
        @(negedge ref_clk_i);
        t0 = now;
        c0 = count[g];
        if (is_rx) rx = 1'b1;
        else tx = 1'b1;
        repeat (hold) @(negedge ref_clk_i);
        rx = 1'b0;
        tx = 1'b0;
        repeat (40) @(negedge ref_clk_i);
        chk("pulse count", c0 + n, count[g]);
        if (n > 0) chk("pulse time", t0 + 2 + lat, stamp[g]);
    endtask : send

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        rd_reg(fsp_pkg::ADDR_SEL_A, fsp_pkg::RST_SEL_A);
        wr_reg(fsp_pkg::ADDR_SYNC, 16'hdf22);
        rd_reg(fsp_pkg::ADDR_SYNC, 16'hdf22);
        wr_reg(fsp_pkg::ADDR_SKEW, 16'hffff);
        rd_reg(fsp_pkg::ADDR_SKEW, 16'h0000);
        rd_reg(10'h3ff, 16'h0000);
        wr_reg(fsp_pkg::ADDR_CONTROL, 16'h4000);
        chk("relink", 1, relink);
        rd_reg(fsp_pkg::ADDR_CONTROL, 16'h0000);
        $display("regs test done");
    endtask : t_regs

    task automatic t_tx();
        wr_reg(fsp_pkg::ADDR_RX_FEATURE, 16'h0080);
        wr_reg(fsp_pkg::ADDR_SEL_A, 16'h1221);
        for (int p = 0; p < 16; p += 5) begin
            wr_reg(fsp_pkg::ADDR_SEL_B, 16'(p));
            send(1'b0, 1, 0, p * fsp_pkg::STEP_CYC, 1);
        end
        send(1'b0, 3, 0, 15 * fsp_pkg::STEP_CYC, 1);
        send(1'b0, 1, 1, 0, 0);
        send(1'b0, 1, 3, 15 * fsp_pkg::STEP_CYC, 1);
        send(1'b1, 1, 2, 0, 1);
        wr_reg(fsp_pkg::ADDR_SEL_A, 16'h0f21);
        send(1'b0, 1, 3, 0, 0);
        send(1'b1, 1, 2, 0, 0);
        $display("tx test done");
    endtask : t_tx

    task automatic t_skew();
        bit g [5] = '{1, 1, 1, 1, 0};
        bit m [5] = '{1, 1, 0, 0, 1};
        logic [3:0] al [5] = '{4'h3, 4'h3, 4'h2, 4'h0, 4'h3};
        logic [15:0] st [5] = '{16'h0000, 16'h0010, 16'h0001, 16'h0000, 16'h0000};
        int ap [5] = '{3, 1, 1, 0, 0};
        wr_reg(fsp_pkg::ADDR_SEL_B, 16'h0020);
        for (int i = 0; i < 5; i++) begin
            wr_reg(fsp_pkg::ADDR_SYNC, (i == 0) ? 16'h0000 : 16'hdf22);
            wr_reg(fsp_pkg::ADDR_CONTROL, 16'h4000);
            lnk = 1'b0;
            gig = g[i];
            mst = m[i];
            skew = al[i];
            repeat (2) @(negedge ref_clk_i);
            lnk = 1'b1;
            repeat (2) @(negedge ref_clk_i);
            skew = ~skew;
            rd_reg(fsp_pkg::ADDR_SKEW, st[i]);
            send(1'b1, 1, 1, (2 + ap[i]) * fsp_pkg::STEP_CYC, 1);
        end
        $display("skew test done");
    endtask : t_skew

    task automatic t_allow();
        wr_reg(fsp_pkg::ADDR_RX_FEATURE, 16'h0000);
        send(1'b0, 1, 0, 0, 0);
        $display("allow test done");
    endtask : t_allow

    // ----------------------------------------
    // Run control
    // ----------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (2) @(negedge ref_clk_i);
        rst_b_i = 1'b1;
        t_regs();
        t_tx();
        t_skew();
        t_allow();
        report_and_stop();
    end

    initial begin
        #(5000 * 25);
        n_fail++;
        $display("Error watchdog expected done seen timeout");
        report_and_stop();
    end
endmodule : tb_top
